// >>> irq_ctrl_defs.svh
`ifndef IRQ_CTRL_DEFS_SVH
`define IRQ_CTRL_DEFS_SVH

// Register offsets within a bank (low seven address bits)
`define OFS_INTERRUPT_CONTROL   7'h0b
`define OFS_PERIPH_FLAGS_ONE    7'h0c
`define OFS_PERIPH_FLAGS_TWO    7'h0d
`define OFS_PERIPH_ENABLES_ONE  7'h0e
`define OFS_PERIPH_ENABLES_TWO  7'h0f
`define OFS_OPTION              7'h01
`define OFS_TIMER_ZERO_COUNT    7'h02
`define OFS_IRQ_STATUS          7'h03
`define OFS_IRQ_MASK            7'h04
`define OFS_COMMON_BASE         7'h70

// Control register bit positions; the edge select bit is in the option register
`define BIT_GLOBAL_IRQ_ENABLE   7
`define BIT_PERIPH_IRQ_ENABLE   6
`define BIT_TIMER_OVF_ENABLE    5
`define BIT_EXT_PIN_ENABLE      4
`define BIT_PORT_CHANGE_ENABLE  3
`define BIT_TIMER_OVF_FLAG      2
`define BIT_EXT_PIN_FLAG        1
`define BIT_PORT_CHANGE_FLAG    0
`define BIT_EXT_EDGE_SELECT     6

// Peripheral source layout: six in register one, one in register two
`define PERIPH_SOURCES          7
`define PERIPH_ONE_MASK         8'h3f
`define PERIPH_TWO_MASK         8'h01

// Reset values
`define RST_INTERRUPT_CONTROL   8'h00
`define RST_OPTION              8'hff
`define RST_PERIPH              8'h00

// Host event status bits
`define STS_VECTOR_TAKEN        0
`define STS_WAKE                1
`define STS_RETURN              2
`define STS_WIDTH               3

// Vector and instruction timing
`define IRQ_VECTOR_ADDR         13'h0004
`define CLOCKS_PER_INSTR_LAST   2'h3
`define TIMER_ROLLOVER          8'hff

`endif

// >>> irq_ctrl_pkg.sv
package irq_ctrl_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SAVE,
      ST_FLUSH
   } entry_state_t;

endpackage : irq_ctrl_pkg

// >>> mcu_interrupt_control.sv
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defs.svh"

module mcu_interrupt_control (
   input  wire logic        MCLK,            // Core clock, 25 MHz
   input  wire logic        SYS_RST,         // Synchronous reset, high
   input  wire logic [8:0]  REG_ADDR,        // Bank in [8:7], offset [6:0]
   input  wire logic [7:0]  REG_WDATA,       // Write data
   input  wire logic        REG_WR,          // Write strobe
   input  wire logic        REG_RD,          // Read strobe
   output logic      [7:0]  REG_RDATA,       // Read data, cycle after strobe
   input  wire logic        EXT_IRQ_PIN,     // External interrupt pin
   input  wire logic [3:0]  UPPER_PORT_PINS, // Port pins 7:4
   input  wire logic        TIMER_INC,       // Timer count increment pulse
   input  wire logic [6:0]  PERIPH_EVENT,    // Peripheral event pulses
   input  wire logic        CORE_SLEEPING,   // Core is in sleep
   input  wire logic        RETURN_FROM_IRQ_INSTR, // Return instruction done
   output logic             INSTR_CYCLE,     // Instruction cycle boundary
   output logic             VECTOR_REQ,      // Enabled request pending
   output logic             STACK_PUSH,      // Push return address
   output logic             PC_LOAD,         // Load program counter
   output logic      [12:0] PC_VALUE,        // Vector address
   output logic             WAKE_REQ,        // Wake core from sleep
   output logic             IRQ_OUT          // Host interrupt, level
);

   ////////////////////////////////////////////////////////////////////////
   logic [1:0]  q_cnt_reg;
   logic        instr_en_reg;
   logic        ext_s1_reg;
   logic        ext_s2_reg;
   logic        ext_s3_reg;
   logic [3:0]  port_s1_reg;
   logic [3:0]  port_s2_reg;
   logic [3:0]  port_s3_reg;
   logic [7:0]  ctl_reg;
   logic [7:0]  ctl_next;
   logic [7:0]  pf1_reg;
   logic [7:0]  pf2_reg;
   logic [7:0]  pe1_reg;
   logic [7:0]  pe2_reg;
   logic [7:0]  option_reg;
   logic [7:0]  timer_reg;
   logic [`STS_WIDTH-1:0] sts_reg;
   logic [`STS_WIDTH-1:0] mask_reg;
   logic [7:0]  common_mem [0:15];
   logic [7:0]  rd_next;
   logic [6:0]  ofs;
   logic        wr_ctl;
   logic        ext_edge;
   logic        port_change;
   logic        timer_ovf;
   logic [6:0]  periph_flags;
   logic [6:0]  periph_enables;
   logic        local_pend;
   logic        periph_pend;
   logic        any_pend;
   logic        accept;
   logic        enter_vector;
   logic [`STS_WIDTH-1:0] sts_set;
   irq_ctrl_pkg::entry_state_t state_reg;
   logic        wr_option;
   logic        wr_timer;
   logic        wr_pf1;
   logic        wr_pf2;
   logic        wr_pe1;
   logic        wr_pe2;
   logic        wr_sts;
   logic        wr_mask;
   logic        wr_common;
   logic [6:0]  periph_hit;
   logic [1:0]  prime_cnt_reg;
   logic        sync_ready;

   // Bank bits are ignored: every register mirrors into all banks
   assign ofs    = REG_ADDR[6:0];
   assign wr_ctl = REG_WR && (ofs == `OFS_INTERRUPT_CONTROL);
   assign wr_option = REG_WR && (ofs == `OFS_OPTION);
   assign wr_timer  = REG_WR && (ofs == `OFS_TIMER_ZERO_COUNT);
   assign wr_pf1    = REG_WR && (ofs == `OFS_PERIPH_FLAGS_ONE);
   assign wr_pf2    = REG_WR && (ofs == `OFS_PERIPH_FLAGS_TWO);
   assign wr_pe1    = REG_WR && (ofs == `OFS_PERIPH_ENABLES_ONE);
   assign wr_pe2    = REG_WR && (ofs == `OFS_PERIPH_ENABLES_TWO);
   assign wr_sts    = REG_WR && (ofs == `OFS_IRQ_STATUS);
   assign wr_mask   = REG_WR && (ofs == `OFS_IRQ_MASK);
   // Common window is offsets 70h-7Fh in every bank
   assign wr_common = REG_WR && (ofs[6:4] == 3'(`OFS_COMMON_BASE >> 4));

   ////////////////////////////////////////////////////////////////////////
   // Instruction cycle enable: four clocks per instruction cycle
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         q_cnt_reg    <= 2'h0;
         instr_en_reg <= 1'b0;
      end else begin
         q_cnt_reg    <= q_cnt_reg + 2'h1;
         instr_en_reg <= (q_cnt_reg == `CLOCKS_PER_INSTR_LAST);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; third stage only for edge and change detect
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         ext_s1_reg  <= 1'b0;
         ext_s2_reg  <= 1'b0;
         ext_s3_reg  <= 1'b0;
         port_s1_reg <= 4'h0;
         port_s2_reg <= 4'h0;
         port_s3_reg <= 4'h0;
      end else begin
         ext_s1_reg  <= EXT_IRQ_PIN;
         ext_s2_reg  <= ext_s1_reg;
         ext_s3_reg  <= ext_s2_reg;
         port_s1_reg <= UPPER_PORT_PINS;
         port_s2_reg <= port_s1_reg;
         port_s3_reg <= port_s2_reg;
      end
   end

   // Detect only once all stages hold pin samples, so a pin that
   // idles high gives no false event right after reset
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         prime_cnt_reg <= 2'h0;
      end else if (prime_cnt_reg != 2'h3) begin
         prime_cnt_reg <= prime_cnt_reg + 2'h1;
      end
   end

   assign sync_ready = (prime_cnt_reg == 2'h3);

   // Option bit 6 high picks rising edges, low picks falling
   assign ext_edge = sync_ready &
                     (option_reg[`BIT_EXT_EDGE_SELECT] ?
                      (ext_s2_reg & ~ext_s3_reg) :
                      (~ext_s2_reg & ext_s3_reg));
   // Any toggle on pins 7:4; a glitch shorter than one clock may be lost
   assign port_change = sync_ready &
                        |(port_s2_reg ^ port_s3_reg);

   ////////////////////////////////////////////////////////////////////////
   // Timer count; a software write wins over an increment
   assign timer_ovf = TIMER_INC && (timer_reg == `TIMER_ROLLOVER)
                      && !wr_timer;

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         timer_reg <= 8'h00;
      end else if (wr_timer) begin
         timer_reg <= REG_WDATA;
      end else if (TIMER_INC) begin
         timer_reg <= timer_reg + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register: hardware sets win over a software write
   always_comb begin
      ctl_next = wr_ctl ? REG_WDATA : ctl_reg;
      if (ext_edge) begin
         ctl_next[`BIT_EXT_PIN_FLAG] = 1'b1;
      end
      if (timer_ovf) begin
         ctl_next[`BIT_TIMER_OVF_FLAG] = 1'b1;
      end
      if (port_change) begin
         ctl_next[`BIT_PORT_CHANGE_FLAG] = 1'b1;
      end
      if (accept) begin
         ctl_next[`BIT_GLOBAL_IRQ_ENABLE] = 1'b0;
      end else if (RETURN_FROM_IRQ_INSTR) begin
         ctl_next[`BIT_GLOBAL_IRQ_ENABLE] = 1'b1;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         ctl_reg <= `RST_INTERRUPT_CONTROL;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Peripheral flags and enables; unimplemented bits stay zero
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         pf1_reg <= `RST_PERIPH;
         pf2_reg <= `RST_PERIPH;
      end else begin
         pf1_reg <= (wr_pf1 ?
                     REG_WDATA : pf1_reg) & `PERIPH_ONE_MASK
                    | {2'h0, PERIPH_EVENT[5:0]};
         pf2_reg <= (wr_pf2 ?
                     REG_WDATA : pf2_reg) & `PERIPH_TWO_MASK
                    | {7'h00, PERIPH_EVENT[6]};
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         pe1_reg <= `RST_PERIPH;
         pe2_reg <= `RST_PERIPH;
      end else begin
         if (wr_pe1) begin
            pe1_reg <= REG_WDATA & `PERIPH_ONE_MASK;
         end
         if (wr_pe2) begin
            pe2_reg <= REG_WDATA & `PERIPH_TWO_MASK;
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         option_reg <= `RST_OPTION;
      end else if (wr_option) begin
         option_reg <= REG_WDATA;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pending logic: three local plus seven peripheral sources
   assign periph_flags   = {pf2_reg[0], pf1_reg[5:0]};
   assign periph_enables = {pe2_reg[0], pe1_reg[5:0]};
   assign local_pend =
      (ctl_reg[`BIT_TIMER_OVF_FLAG] & ctl_reg[`BIT_TIMER_OVF_ENABLE]) |
      (ctl_reg[`BIT_EXT_PIN_FLAG] & ctl_reg[`BIT_EXT_PIN_ENABLE]) |
      (ctl_reg[`BIT_PORT_CHANGE_FLAG] &
       ctl_reg[`BIT_PORT_CHANGE_ENABLE]);
   // One gate per peripheral source; none outranks another
   for (genvar i = 0; i < `PERIPH_SOURCES; i++) begin : g_periph
      assign periph_hit[i] = periph_flags[i] & periph_enables[i];
   end
   assign periph_pend = ctl_reg[`BIT_PERIPH_IRQ_ENABLE] &
                        |periph_hit;
   assign any_pend = local_pend | periph_pend;
   // No priority among sources; software polls the flags
   assign accept = instr_en_reg && (state_reg == irq_ctrl_pkg::ST_IDLE)
                   && any_pend
                   && ctl_reg[`BIT_GLOBAL_IRQ_ENABLE];
   assign enter_vector = instr_en_reg &&
                         (state_reg == irq_ctrl_pkg::ST_FLUSH);

   ////////////////////////////////////////////////////////////////////////
   // Entry sequence: accept, one save cycle, one flush cycle, then vector load.
   // Counted in instruction cycles, so instruction length never matters.
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         state_reg <= irq_ctrl_pkg::ST_IDLE;
      end else if (instr_en_reg) begin
         case (state_reg)
            irq_ctrl_pkg::ST_IDLE: begin
               if (accept) begin
                  state_reg <= irq_ctrl_pkg::ST_SAVE;
               end
            end
            irq_ctrl_pkg::ST_SAVE: begin
               state_reg <= irq_ctrl_pkg::ST_FLUSH;
            end
            irq_ctrl_pkg::ST_FLUSH: begin
               state_reg <= irq_ctrl_pkg::ST_IDLE;
            end
            default: begin
               state_reg <= irq_ctrl_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         INSTR_CYCLE <= 1'b0;
         VECTOR_REQ  <= 1'b0;
         STACK_PUSH  <= 1'b0;
         PC_LOAD     <= 1'b0;
         PC_VALUE    <= 13'h0000;
         WAKE_REQ    <= 1'b0;
      end else begin
         INSTR_CYCLE <= instr_en_reg;
         VECTOR_REQ  <= any_pend &
                        ctl_reg[`BIT_GLOBAL_IRQ_ENABLE];
         // Only the return address is saved; context is software's job
         STACK_PUSH  <= accept;
         PC_LOAD     <= enter_vector;
         PC_VALUE    <= `IRQ_VECTOR_ADDR;
         // Wake ignores the global enable; the core then decides
         WAKE_REQ    <= CORE_SLEEPING & any_pend;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Host event status, write one to clear, set wins
   assign sts_set = {RETURN_FROM_IRQ_INSTR, CORE_SLEEPING & any_pend,
                     accept};

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         sts_reg <= '0;
      end else if (wr_sts) begin
         sts_reg <= (sts_reg & ~REG_WDATA[`STS_WIDTH-1:0]) | sts_set;
      end else begin
         sts_reg <= sts_reg | sts_set;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         mask_reg <= '0;
      end else if (wr_mask) begin
         mask_reg <= REG_WDATA[`STS_WIDTH-1:0];
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         IRQ_OUT <= 1'b0;
      end else begin
         IRQ_OUT <= |(sts_reg & mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Common bytes: same storage whatever the bank bits say
   always_ff @(posedge MCLK) begin
      if (wr_common) begin
         common_mem[ofs[3:0]] <= REG_WDATA;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path; unmapped offsets read zero
   always_comb begin
      rd_next = 8'h00;
      if (ofs[6:4] == 3'(`OFS_COMMON_BASE >> 4)) begin
         rd_next = common_mem[ofs[3:0]];
      end else begin
         case (ofs)
            `OFS_INTERRUPT_CONTROL:  rd_next = ctl_reg;
            `OFS_PERIPH_FLAGS_ONE:   rd_next = pf1_reg;
            `OFS_PERIPH_FLAGS_TWO:   rd_next = pf2_reg;
            `OFS_PERIPH_ENABLES_ONE: rd_next = pe1_reg;
            `OFS_PERIPH_ENABLES_TWO: rd_next = pe2_reg;
            `OFS_OPTION:             rd_next = option_reg;
            `OFS_TIMER_ZERO_COUNT:   rd_next = timer_reg;
            `OFS_IRQ_STATUS:         rd_next = {5'h00, sts_reg};
            `OFS_IRQ_MASK:           rd_next = {5'h00, mask_reg};
            default:                 rd_next = 8'h00;
         endcase
      end
   end

   // Zero outside the answer cycle, so stale data never lingers
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         REG_RDATA <= 8'h00;
      end else begin
         REG_RDATA <= REG_RD ? rd_next : 8'h00;
      end
   end

endmodule : mcu_interrupt_control

`default_nettype wire

// >>> mcu_interrupt_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_checker (
   input wire logic        MCLK,          // Clock
   input wire logic        SYS_RST,       // Reset
   input wire logic        CORE_SLEEPING, // Core asleep
   input wire logic        INSTR_CYCLE,   // Boundary
   input wire logic        VECTOR_REQ,    // Request
   input wire logic        STACK_PUSH,    // Push
   input wire logic        PC_LOAD,       // Load
   input wire logic [12:0] PC_VALUE,      // Vector
   input wire logic        WAKE_REQ       // Wake
);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (SYS_RST);
   sequence s_load;
      PC_LOAD && PC_VALUE == 13'h0004;
   endsequence
   sequence s_quiet;
      !INSTR_CYCLE [*3];
   endsequence
   property p_entry; STACK_PUSH |-> ##8 s_load; endproperty
   a_entry: assert property (p_entry)
      else $error("no vector load 8 clocks after push");
   property p_load_src; PC_LOAD |-> $past(STACK_PUSH, 8); endproperty
   a_load_src: assert property (p_load_src)
      else $error("load without push");
   property p_enable_drop; STACK_PUSH |=> !VECTOR_REQ; endproperty
   a_enable_drop: assert property (p_enable_drop)
      else $error("request stays after entry");
   property p_boundary; STACK_PUSH |-> INSTR_CYCLE; endproperty
   a_boundary: assert property (p_boundary)
      else $error("push off boundary");
   property p_cadence; INSTR_CYCLE |=> s_quiet ##1 INSTR_CYCLE; endproperty
   a_cadence: assert property (p_cadence)
      else $error("boundary period not 4");
   property p_cause; STACK_PUSH |-> VECTOR_REQ || $past(VECTOR_REQ); endproperty
   a_cause: assert property (p_cause)
      else $error("push without request");
   property p_single; STACK_PUSH |=> !STACK_PUSH [*8]; endproperty
   a_single: assert property (p_single)
      else $error("second accept before load");
   property p_reset_enable; $fell(SYS_RST) |-> !VECTOR_REQ [*2]; endproperty
   a_reset_enable: assert property (p_reset_enable)
      else $error("request right after reset");
   property p_wake; WAKE_REQ |-> $past(CORE_SLEEPING); endproperty
   a_wake: assert property (p_wake)
      else $error("wake while awake");
endmodule : irq_ctrl_checker

bind mcu_interrupt_control irq_ctrl_checker i_chk (
   .MCLK(MCLK), .SYS_RST(SYS_RST), .CORE_SLEEPING(CORE_SLEEPING),
   .INSTR_CYCLE(INSTR_CYCLE), .VECTOR_REQ(VECTOR_REQ),
   .STACK_PUSH(STACK_PUSH), .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE),
   .WAKE_REQ(WAKE_REQ));
`default_nettype wire

// >>> core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model #(
   parameter int RET_DELAY = 24 // Handler length in clocks
) (
   input  wire logic clk,       // Core clock
   input  wire logic rst,       // Synchronous reset
   input  wire logic pc_load,   // Vector taken
   input  wire logic wake_req,  // Wake request
   input  wire logic sleep_cmd, // Enter sleep
   output logic      sleeping,  // Core asleep
   output logic      return_from_irq_instr // Return pulse
);
   logic [7:0] cnt_reg;
   // Long enough for the handler to clear its flag first
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg               <= 8'h00;
         return_from_irq_instr <= 1'b0;
      end else begin
         return_from_irq_instr <= (cnt_reg == 8'h01);
         if (pc_load)
            cnt_reg <= 8'(RET_DELAY);
         else if (cnt_reg != 8'h00)
            cnt_reg <= cnt_reg - 8'h01;
      end
   end
   always_ff @(posedge clk) begin
      if (rst)
         sleeping <= 1'b0;
      else if (wake_req)
         sleeping <= 1'b0;
      else if (sleep_cmd)
         sleeping <= 1'b1;
   end
endmodule : core_model
`default_nettype wire

// >>> mcu_interrupt_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_interrupt_control_test;
   logic        mclk = 1'b0;
   logic        rst  = 1'b1;
   logic [8:0]  addr = 9'h000;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        pin = 1'b0;
   logic [3:0]  port = 4'h0;
   logic        tinc = 1'b0;
   logic [6:0]  pev = 7'h00;
   logic        sleep_cmd = 1'b0;
   logic [7:0]  rdata;
   logic [12:0] pcv;
   logic        sleeping, ret_instr, instr, vreq, push, pcld, wake, irq;
   int          bad_count = 0;
   int          comparisons = 0;
   int          n;

   always #20 mclk = ~mclk;

   mcu_interrupt_control i_dut (
      .MCLK(mclk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .EXT_IRQ_PIN(pin),
      .UPPER_PORT_PINS(port), .TIMER_INC(tinc), .PERIPH_EVENT(pev),
      .CORE_SLEEPING(sleeping), .RETURN_FROM_IRQ_INSTR(ret_instr),
      .INSTR_CYCLE(instr),
      .VECTOR_REQ(vreq), .STACK_PUSH(push), .PC_LOAD(pcld), .PC_VALUE(pcv),
      .WAKE_REQ(wake), .IRQ_OUT(irq));
   core_model i_core (
      .clk(mclk), .rst(rst), .pc_load(pcld), .wake_req(wake),
      .sleep_cmd(sleep_cmd), .sleeping(sleeping),
      .return_from_irq_instr(ret_instr));

   task automatic chk(input string what, input logic [12:0] e,
                      input logic [12:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s exp %h got %h", what, e, g);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
   endtask : cyc
   task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd   <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), 13'(e), 13'(rdata));
   endtask : rd_chk
   task automatic drive_pin(input logic v);
      @(posedge mclk);
      pin <= v;
      cyc(6);
   endtask : drive_pin
   // Bounded wait for a wake or vector-load pulse
   task automatic wait_for(input bit on_wake, output int cnt);
      cnt = 0;
      while ((on_wake ? wake : pcld) !== 1'b1 && cnt < 40) begin
         @(posedge mclk);
         #1;
         cnt++;
      end
   endtask : wait_for
   task automatic report_and_stop();
      if (bad_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////
   task automatic t_flags();
      rd_chk(9'h00b, 8'h00);
      rd_chk(9'h001, 8'hff);
      rd_chk(9'h010, 8'h00);
      drive_pin(1'b1);
      rd_chk(9'h00b, 8'h02);
      wr_reg(9'h00b, 8'h00);
      wr_reg(9'h001, 8'hbf);
      drive_pin(1'b0);
      rd_chk(9'h00b, 8'h02);
      wr_reg(9'h00b, 8'h00);
      drive_pin(1'b1);
      rd_chk(9'h00b, 8'h00);
      wr_reg(9'h002, 8'hff);
      @(posedge mclk);
      tinc <= 1'b1;
      port <= 4'h8;
      pev  <= 7'h7f;
      @(posedge mclk);
      tinc <= 1'b0;
      pev  <= 7'h00;
      cyc(6);
      rd_chk(9'h002, 8'h00);
      rd_chk(9'h00b, 8'h05);
      rd_chk(9'h00c, 8'h3f);
      rd_chk(9'h00d, 8'h01);
      wr_reg(9'h00b, 8'h6d);
      cyc(3);
      chk("vreq", 13'h0, 13'(vreq));
      wr_reg(9'h00b, 8'h00);
      wr_reg(9'h00c, 8'h00);
      wr_reg(9'h00d, 8'h00);
   endtask : t_flags
   task automatic t_vector();
      wr_reg(9'h00b, 8'h90);
      @(posedge mclk);
      pin <= 1'b0;
      wait_for(1'b0, n);
      chk("latency", 13'h1, 13'(n >= 12 && n <= 16));
      chk("pc", 13'h0004, pcv);
      rd_chk(9'h00b, 8'h12);
      wr_reg(9'h00b, 8'h10);
      cyc(30);
      rd_chk(9'h00b, 8'h90);
   endtask : t_vector
   task automatic t_status();
      rd_chk(9'h003, 8'h05);
      chk("irq", 13'h0, 13'(irq));
      wr_reg(9'h004, 8'h04);
      cyc(2);
      chk("irq", 13'h1, 13'(irq));
      wr_reg(9'h003, 8'h04);
      cyc(2);
      chk("irq", 13'h0, 13'(irq));
      rd_chk(9'h003, 8'h01);
   endtask : t_status
   task automatic t_periph();
      wr_reg(9'h00e, 8'h01);
      wr_reg(9'h00b, 8'h80);
      @(posedge mclk);
      pev <= 7'h01;
      @(posedge mclk);
      pev <= 7'h00;
      cyc(12);
      chk("vreq", 13'h0, 13'(vreq));
      wr_reg(9'h00b, 8'hc0);
      wait_for(1'b0, n);
      chk("load", 13'h1, 13'(pcld));
      wr_reg(9'h00c, 8'h00);
      cyc(30);
      rd_chk(9'h00b, 8'hc0);
   endtask : t_periph
   task automatic t_sleep();
      wr_reg(9'h00b, 8'h10);
      @(posedge mclk);
      sleep_cmd <= 1'b1;
      @(posedge mclk);
      sleep_cmd <= 1'b0;
      drive_pin(1'b1);
      @(posedge mclk);
      pin <= 1'b0;
      wait_for(1'b1, n);
      chk("wake", 13'h1, 13'(wake));
      wait_for(1'b0, n);
      chk("load", 13'h0, 13'(pcld));
      rd_chk(9'h00b, 8'h12);
      wr_reg(9'h070, 8'h5a);
      rd_chk(9'h1f0, 8'h5a);
   endtask : t_sleep

   initial begin
      cyc(5);
      rst <= 1'b0;
      t_flags();
      t_vector();
      t_status();
      t_periph();
      t_sleep();
      report_and_stop();
   end
   initial begin
      cyc(4000);
      bad_count++;
      report_and_stop();
   end
endmodule : mcu_interrupt_control_test
`default_nettype wire
